// >>> rtl/dsgate_top.sv
/*
 * Unit clock gating control with run, sleep and deep-sleep enable sets,
 * bus-fault detection on gated units and an Avalon-MM register slave.
 * Assumes the power controller and the bus fabric run on clock.
 */
// Implementation choice: register access over Avalon-MM.
// Function
// - Set bit clocks unit; clear bit stops it.
// - Access to gated unit answers bus fault.
// - Gating register resets to all zeros.
// - Deep-sleep register sits at offset 0x124.
// - Separate run, sleep, deep-sleep enable registers.
// - Sleep sets apply only with auto gating.
// - Bit 24 comparator; 31:25, 23:19 reserved.
// - Bits 16..18 gate counters zero..two.
// - Bit 4 sync serial; 15:5, 3:2 reserved.
// - Bit 1 gates async serial one.
// - Bit 0 gates async serial zero.
`timescale 1ns/100ps
module dsgate_top
    import dsgate_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        clockEn,
    input  wire logic [11:0] address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [3:0]  byteenable,
    input  wire logic [31:0] writedata,
    output logic      [31:0] readdata,
    output logic      [1:0]  response,
    output logic             waitrequest,
    input  wire logic [1:0]  powerMode,
    input  wire logic [6:0]  unitAccess,
    output logic      [6:0]  unitFault,
    output logic      [6:0]  unitClockEnable,
    output wire logic [6:0]  unitClock,
    output logic             irq
);

    typedef struct packed {
        logic [31:0] runReg;
        logic [31:0] sleepReg;
        logic [31:0] deepReg;
        logic [31:0] runClkReg;
        logic [31:0] statusReg;
        logic [31:0] maskReg;
        logic [31:0] rdataReg;
        logic [1:0]  respReg;
        dsgate_bus_t busState;
        logic [6:0]  faultReg;
        logic [6:0]  enableReg;
    } dsgate_state_t;

    dsgate_state_t st;
    dsgate_state_t nx;

    function automatic logic [6:0] gather(input logic [31:0] word);
        logic [6:0] v;
        v = '0;
        for (int i = 0; i < UNIT_COUNT; i++) begin
            v[i] = word[UNIT_POS[i]];
        end
        return v;
    endfunction

    function automatic logic [31:0] spread(input logic [6:0] v);
        logic [31:0] word;
        word = '0;
        for (int i = 0; i < UNIT_COUNT; i++) begin
            word[UNIT_POS[i]] = v[i];
        end
        return word;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wdata,
                                          input logic [3:0]  be,
                                          input logic [31:0] wmask);
        logic [31:0] m;
        m = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                m[8*b +: 8] = wdata[8*b +: 8];
            end
        end
        return m & wmask;
    endfunction

    function automatic logic isMapped(input logic [11:0] a);
        return a == RUN_GATE_OFS || a == SLEEP_GATE_OFS || a == DEEP_GATE_OFS
            || a == RUN_CLK_CFG_OFS || a == IRQ_STATUS_OFS || a == IRQ_MASK_OFS;
    endfunction

    logic [31:0] gateSource;
    logic [31:0] stickyClear;
    logic        autoGate;
    logic        request;

    assign autoGate = st.runClkReg[AUTO_CLOCK_GATE_SELECT_POS];
    assign request  = read | write;

    always_comb begin
        nx          = st;
        gateSource  = st.runReg;
        stickyClear = '0;
        // Sleep and deep-sleep sets only take over when auto gating is on.
        unique case (powerMode)
            MODE_SLEEP: gateSource = autoGate ? st.sleepReg : st.runReg;
            MODE_DEEP:  gateSource = autoGate ? st.deepReg : st.runReg;
            default:    gateSource = st.runReg;
        endcase
        if (clockEn) begin
            nx.enableReg = gather(gateSource);
            nx.faultReg  = unitAccess & ~st.enableReg;
            unique case (st.busState)
                BUS_IDLE: begin
                    if (request) begin
                        nx.busState = BUS_ACK;
                        nx.respReg  = isMapped(address) ? RESP_OKAY : RESP_DECODEERROR;
                        unique case (address)
                            RUN_GATE_OFS:    nx.rdataReg = st.runReg;
                            SLEEP_GATE_OFS:  nx.rdataReg = st.sleepReg;
                            DEEP_GATE_OFS:   nx.rdataReg = st.deepReg;
                            RUN_CLK_CFG_OFS: nx.rdataReg = st.runClkReg;
                            IRQ_STATUS_OFS:  nx.rdataReg = st.statusReg;
                            IRQ_MASK_OFS:    nx.rdataReg = st.maskReg;
                            default:         nx.rdataReg = '0;
                        endcase
                        if (write) begin
                            nx.rdataReg = '0;
                        end
                    end
                end
                BUS_ACK: begin
                    nx.busState = BUS_IDLE;
                    if (write && isMapped(address)) begin
                        // Write masks drop every reserved bit, so they stay zero.
                        unique case (address)
                            RUN_GATE_OFS:
                                nx.runReg = merge(st.runReg, writedata, byteenable,
                                                  GATE_WMASK);
                            SLEEP_GATE_OFS:
                                nx.sleepReg = merge(st.sleepReg, writedata, byteenable,
                                                    GATE_WMASK);
                            DEEP_GATE_OFS:
                                nx.deepReg = merge(st.deepReg, writedata, byteenable,
                                                   GATE_WMASK);
                            RUN_CLK_CFG_OFS:
                                nx.runClkReg = merge(st.runClkReg, writedata, byteenable,
                                                     RUN_CLK_WMASK);
                            IRQ_STATUS_OFS:
                                stickyClear = merge('0, writedata, byteenable, GATE_WMASK);
                            default:
                                nx.maskReg = merge(st.maskReg, writedata, byteenable,
                                                   GATE_WMASK);
                        endcase
                    end
                end
            endcase
            // A fault in the clearing cycle keeps its status bit set.
            nx.statusReg = (st.statusReg & ~stickyClear) | spread(nx.faultReg);
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st           <= '0;
            st.runReg    <= GATE_RESET;
            st.sleepReg  <= GATE_RESET;
            st.deepReg   <= GATE_RESET;
            st.runClkReg <= RUN_CLK_RESET;
            st.statusReg <= IRQ_RESET;
            st.maskReg   <= IRQ_RESET;
            st.busState  <= BUS_IDLE;
        end else begin
            st <= nx;
        end
    end

    assign readdata        = st.rdataReg;
    assign response        = st.respReg;
    assign waitrequest     = request & ~((st.busState == BUS_ACK) & clockEn);
    assign unitFault       = st.faultReg;
    assign unitClockEnable = st.enableReg;
    assign irq             = |(st.statusReg & st.maskReg);

    for (genvar g = 0; g < UNIT_COUNT; g++) begin : gen_gate
        dsgate_clock_gate u_gate (
            .clock      (clock),
            .rst        (rst),
            .clockEn    (clockEn),
            .enable     (st.enableReg[g]),
            .gatedClock (unitClock[g])
        );
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    AST_RUN_FOLLOWS: assert property (
        clockEn && powerMode == MODE_RUN |=> unitClockEnable == gather($past(st.runReg)))
        else $error("Run-mode enables not applied.");

    AST_DEEP_AUTO: assert property (
        clockEn && powerMode == MODE_DEEP && autoGate
        |=> unitClockEnable == gather($past(st.deepReg)))
        else $error("Deep-sleep enables not applied with auto gating.");

    AST_SLEEP_NO_AUTO: assert property (
        clockEn && powerMode == MODE_SLEEP && !autoGate
        |=> unitClockEnable == gather($past(st.runReg)))
        else $error("Sleep mode without auto gating must use run enables.");

    AST_FAULT_GATED: assert property (
        clockEn && (unitAccess & ~unitClockEnable) != 7'h00
        |=> unitFault == $past(unitAccess & ~unitClockEnable)
            && (!(|(spread(unitFault) & st.maskReg)) || irq)
            && (gather(st.statusReg) & unitFault) == unitFault)
        else $error("Access to gated unit did not fault.");

    AST_NO_FAULT_CLOCKED: assert property (
        clockEn && (unitAccess & ~unitClockEnable) == 7'h00 |=> unitFault == 7'h00)
        else $error("Fault raised for a clocked unit.");

    AST_RESET_ZERO: assert property (
        $past(rst) |-> st.deepReg == GATE_RESET && unitClockEnable == 7'h00)
        else $error("Gating register not zero after reset.");

    AST_READ_DEEP: assert property (
        clockEn && st.busState == BUS_IDLE && read && address == DEEP_GATE_OFS
        |=> readdata == $past(st.deepReg) && response == RESP_OKAY && !waitrequest || !clockEn)
        else $error("Deep-sleep register read at its offset failed.");

    AST_WRITE_ALL: assert property (
        clockEn && st.busState == BUS_ACK && write && address == DEEP_GATE_OFS
        && byteenable == 4'hF && writedata == 32'hFFFF_FFFF |=> st.deepReg == 32'h0107_0013)
        else $error("Writable gate bits or reserved bits wrong.");

    AST_RSVD_ZERO: assert property (
        ((st.runReg | st.sleepReg | st.deepReg) & 32'hFEF8_FFEC) == 32'h0000_0000)
        else $error("Reserved gate bit became set.");

    AST_FROZEN: assert property (
        !clockEn |=> unitClockEnable == $past(unitClockEnable) && unitFault == $past(unitFault)
            && st.statusReg == $past(st.statusReg))
        else $error("State moved while the clock enable was low.");

    AST_SLEEP_AUTO: assert property (
        clockEn && powerMode == MODE_SLEEP && autoGate
        |=> unitClockEnable == gather($past(st.sleepReg)))
        else $error("Sleep enables not applied with auto gating.");

    AST_DEEP_NO_AUTO: assert property (
        clockEn && powerMode == MODE_DEEP && !autoGate
        |=> unitClockEnable == gather($past(st.runReg)))
        else $error("Deep-sleep mode without auto gating must use run enables.");

    AST_MODE_ILLEGAL: assert property (
        clockEn && powerMode == 2'h2 |=> unitClockEnable == gather($past(st.runReg)))
        else $error("Unused power mode code must use run enables.");

    AST_DEEP_WRITE: assert property (
        clockEn && st.busState == BUS_ACK && write && address == DEEP_GATE_OFS
        && byteenable == 4'hF |=> st.deepReg == ($past(writedata) & 32'h0107_0013))
        else $error("Full write at the deep-sleep offset did not land.");

    AST_DEEP_ONLY: assert property (
        !(clockEn && st.busState == BUS_ACK && write && address == DEEP_GATE_OFS)
        |=> st.deepReg == $past(st.deepReg))
        else $error("Deep-sleep register changed without a write to its offset.");

    AST_UNMAPPED: assert property (
        clockEn && st.busState == BUS_IDLE && (read || write) && address > 12'h204
        |=> response == RESP_DECODEERROR && readdata == 32'h0000_0000)
        else $error("Unmapped offset not answered with a decode error.");

    AST_ONE_WAIT: assert property (
        clockEn && st.busState == BUS_IDLE && (read || write) |=> !waitrequest || !clockEn)
        else $error("Register access not answered after one wait state.");

    AST_READ_RUN: assert property (
        clockEn && st.busState == BUS_IDLE && read && address == RUN_GATE_OFS
        |=> readdata == $past(st.runReg) && response == RESP_OKAY)
        else $error("Run enable register read at its offset failed.");

    AST_STATUS_CLEAR: assert property (
        clockEn && st.busState == BUS_ACK && write && address == IRQ_STATUS_OFS
        && byteenable == 4'hF && (unitAccess & ~unitClockEnable) == 7'h00
        |=> (gather(st.statusReg) & gather($past(writedata))) == 7'h00)
        else $error("Writing a one did not clear a status bit.");

    AST_RUN_CLK_BITS: assert property (
        (st.runClkReg & 32'hF7FF_FFFF) == 32'h0000_0000)
        else $error("Only the auto gating bit may be set in the clock configuration.");

    AST_RESET_ALL: assert property (
        $past(rst) |-> st.runReg == 32'h0000_0000 && st.sleepReg == 32'h0000_0000
            && st.statusReg == 32'h0000_0000 && !irq)
        else $error("Enable or status registers not zero after reset.");

endmodule

// >>> common/dsgate_pkg.sv
/*
 * Shared constants and types of the deep-sleep unit clock gating block.
 * Assumes a 12-bit byte offset inside the system control window.
 */
package dsgate_pkg;

    localparam logic [31:0] SYSCTL_BASE_ADDR = 32'h400F_E000;

    localparam logic [11:0] RUN_GATE_OFS    = 12'h100;
    localparam logic [11:0] SLEEP_GATE_OFS  = 12'h110;
    localparam logic [11:0] DEEP_GATE_OFS   = 12'h124;
    localparam logic [11:0] RUN_CLK_CFG_OFS = 12'h060;
    localparam logic [11:0] IRQ_STATUS_OFS  = 12'h200;
    localparam logic [11:0] IRQ_MASK_OFS    = 12'h204;

    localparam int unsigned ASYNC_SERIAL_ZERO_GATE_POS = 0;
    localparam int unsigned ASYNC_SERIAL_ONE_GATE_POS  = 1;
    localparam int unsigned SYNC_SERIAL_ZERO_GATE_POS  = 4;
    localparam int unsigned GP_COUNTER_ZERO_GATE_POS   = 16;
    localparam int unsigned GP_COUNTER_ONE_GATE_POS    = 17;
    localparam int unsigned GP_COUNTER_TWO_GATE_POS    = 18;
    localparam int unsigned COMPARATOR_ZERO_GATE_POS   = 24;
    localparam int unsigned AUTO_CLOCK_GATE_SELECT_POS = 27;

    localparam int unsigned UNIT_COUNT = 7;
    localparam int unsigned UNIT_POS [UNIT_COUNT] = '{
        ASYNC_SERIAL_ZERO_GATE_POS, ASYNC_SERIAL_ONE_GATE_POS,
        SYNC_SERIAL_ZERO_GATE_POS, GP_COUNTER_ZERO_GATE_POS,
        GP_COUNTER_ONE_GATE_POS, GP_COUNTER_TWO_GATE_POS,
        COMPARATOR_ZERO_GATE_POS};

    localparam logic [31:0] GATE_WMASK      = 32'h0107_0013;
    localparam logic [31:0] RUN_CLK_WMASK   = 32'h0800_0000;
    localparam logic [31:0] GATE_RESET      = 32'h0000_0000;
    localparam logic [31:0] RUN_CLK_RESET   = 32'h0000_0000;
    localparam logic [31:0] IRQ_RESET       = 32'h0000_0000;

    localparam logic [1:0] RESP_OKAY        = 2'h0;
    localparam logic [1:0] RESP_DECODEERROR = 2'h3;

    localparam logic [1:0] MODE_RUN   = 2'h0;
    localparam logic [1:0] MODE_SLEEP = 2'h1;
    localparam logic [1:0] MODE_DEEP  = 2'h3;

    typedef enum logic [0:0] {
        BUS_IDLE = 1'h0,
        BUS_ACK  = 1'h1
    } dsgate_bus_t;

endpackage

// >>> rtl/dsgate_clock_gate.sv
/*
 * Glitch-free clock gate for one controlled unit.
 * Assumes the enable changes only after rising edges of clock.
 */
`timescale 1ns/100ps
module dsgate_clock_gate (
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic clockEn,
    input  wire logic enable,
    output wire logic gatedClock
);

    typedef struct packed {
        logic enableLow;
    } dsgate_gate_state_t;

    dsgate_gate_state_t st;
    dsgate_gate_state_t nx;

    // The enable is taken at the falling edge of clock, so the AND never chops a high phase.
    always_comb begin
        nx = st;
        if (clockEn) begin
            nx.enableLow = enable;
        end
    end

    always_ff @(negedge clock or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= nx;
        end
    end

    assign gatedClock = clock & st.enableLow;

endmodule

// >>> sim/dsgate_core_model.sv
/*
 * Processor core model: an Avalon-MM master that issues single register reads and writes.
 * Assumes the slave answers on clock and the bench watchdog ends any hang.
 */
`timescale 1ns/100ps
module dsgate_core_model (
    input  wire logic        clock,
    output logic      [11:0] address,
    output logic             read,
    output logic             write,
    output logic      [3:0]  byteenable,
    output logic      [31:0] writedata,
    input  wire logic [31:0] readdata,
    input  wire logic [1:0]  response,
    input  wire logic        waitrequest
);
    initial begin
        address    = '0;
        read       = 1'b0;
        write      = 1'b0;
        byteenable = '0;
        writedata  = '0;
    end

    // The request stands until a rising edge sees waitrequest low; data is taken at that edge.
    task automatic access(input logic wr, input logic [11:0] a, input logic [31:0] d,
                          input logic [3:0] be, output logic [31:0] q, output logic [1:0] r);
        @(posedge clock);
        address    <= a;
        write      <= wr;
        read       <= !wr;
        writedata  <= d;
        byteenable <= be;
        @(posedge clock);
        while (waitrequest !== 1'b0) begin
            @(posedge clock);
        end
        q = readdata;
        r = response;
        read      <= 1'b0;
        write     <= 1'b0;
        address   <= ~a;
        writedata <= ~d;
    endtask

    // Only the named bits are set; every other bit goes back as it was read.
    task automatic setBits(input logic [11:0] a, input logic [31:0] bits);
        logic [31:0] q;
        logic [1:0]  r;
        access(1'b0, a, '0, 4'hF, q, r);
        access(1'b1, a, q | bits, 4'hF, q, r);
    endtask
endmodule

// >>> sim/tb.sv
/*
 * Self-checking bench of the unit clock gating block.
 * Assumes the design package and a 40 MHz clock.
 */
`timescale 1ns/100ps
module tb;
    import dsgate_pkg::*;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic        clockEn = 1'b1;
    logic [1:0]  powerMode = MODE_RUN;
    logic [6:0]  unitAccess = '0;
    logic [11:0] address;
    logic        read, write, waitrequest, irq;
    logic [3:0]  byteenable;
    logic [31:0] writedata, readdata, q;
    logic [1:0]  response, r;
    logic [6:0]  unitFault, unitClockEnable, unitClock;
    int          badCount = 0;
    int          nChecks = 0;
    localparam logic [11:0] OFS [6] = '{12'h124, 12'h100, 12'h110, 12'h060, 12'h200, 12'h204};

    always #12.5 clock = ~clock;

    dsgate_top i_dsgate_top (.clock(clock), .rst(rst), .clockEn(clockEn), .address(address),
        .read(read), .write(write), .byteenable(byteenable), .writedata(writedata),
        .readdata(readdata), .response(response), .waitrequest(waitrequest),
        .powerMode(powerMode), .unitAccess(unitAccess), .unitFault(unitFault),
        .unitClockEnable(unitClockEnable), .unitClock(unitClock), .irq(irq));
    dsgate_core_model i_dsgate_core_model (.clock(clock), .address(address), .read(read),
        .write(write), .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
        .response(response), .waitrequest(waitrequest));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        nChecks++;
        if (seen !== exp) begin
            badCount++;
            $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] be = 4'hF);
        i_dsgate_core_model.access(1'b1, a, d, be, q, r);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er = 2'h0);
        i_dsgate_core_model.access(1'b0, a, '0, 4'hF, q, r);
        chk(q, exp);
        chk(r, er);
    endtask

    task automatic mode(input logic [1:0] m, input logic [6:0] exp);
        @(posedge clock);
        powerMode <= m;
        repeat (3) @(posedge clock);
        #1;
        chk(unitClockEnable, exp);
        chk(unitClock, exp);
        @(negedge clock);
        #1;
        chk(unitClock, 7'h00);
    endtask

    task automatic poke(input logic [6:0] u, input logic [6:0] expFault, input logic expIrq);
        @(posedge clock);
        unitAccess <= u;
        @(posedge clock);
        unitAccess <= '0;
        #1;
        chk(unitFault, expFault);
        chk(irq, expIrq);
    endtask

    task automatic stopTest;
        $display("Checks %0d, mismatches %0d", nChecks, badCount);
        if (badCount == 0 && nChecks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial begin
        #(20000 * 25);
        badCount++;
        stopTest();
    end

    initial begin
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        foreach (OFS[i]) rd(OFS[i], 32'h0000_0000);
        wr(12'h124, 32'hFFFF_FFFF);
        rd(12'h124, 32'h0107_0013);
        for (int i = 0; i < 32; i++) begin
            wr(12'h124, 32'h1 << i);
            rd(12'h124, (32'h1 << i) & 32'h0107_0013);
        end
        wr(12'h124, 32'h0107_0013);
        wr(12'h124, 32'h0000_0000, 4'h4);
        rd(12'h124, 32'h0100_0013);
        wr(12'h3FC, 32'hFFFF_FFFF);
        rd(12'h3FC, 32'h0000_0000, 2'h3);
        wr(12'h100, 32'h0000_0013);
        wr(12'h110, 32'h0001_0000);
        wr(12'h124, 32'h0100_0002);
        mode(MODE_DEEP, 7'h07);
        i_dsgate_core_model.setBits(12'h060, 32'h0800_0000);
        rd(12'h060, 32'h0800_0000);
        mode(MODE_DEEP, 7'h42);
        mode(MODE_SLEEP, 7'h08);
        mode(2'h2, 7'h07);
        mode(MODE_RUN, 7'h07);
        wr(12'h204, 32'h0100_0000);
        poke(7'h40, 7'h40, 1'b1);
        rd(12'h200, 32'h0100_0000);
        wr(12'h200, 32'h0100_0000);
        #1;
        chk(irq, 1'b0);
        poke(7'h08, 7'h08, 1'b0);
        // Units are enabled before the fabric touches them.
        i_dsgate_core_model.setBits(12'h100, 32'h0100_0000);
        repeat (2) @(posedge clock);
        poke(7'h41, 7'h00, 1'b0);
        // With the clock enable low, neither a mode change nor a gated access may act.
        @(posedge clock);
        clockEn    <= 1'b0;
        powerMode  <= MODE_DEEP;
        unitAccess <= 7'h08;
        repeat (2) @(posedge clock);
        #1;
        chk(unitClockEnable, 7'h47);
        chk(unitFault, 7'h00);
        @(posedge clock);
        clockEn    <= 1'b1;
        powerMode  <= MODE_RUN;
        unitAccess <= '0;
        rd(12'h200, 32'h0001_0000);
        // A second reset in mid-run must bring every enable back to zero.
        @(posedge clock);
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        #1;
        chk(unitClockEnable, 7'h00);
        rd(12'h124, 32'h0000_0000);
        rd(12'h100, 32'h0000_0000);
        stopTest();
    end
endmodule
